// file: hdl/adcc_control.sv
// Register file, start sequencing, routing and clock divider of the ADC
// How it works
// - Alignment bit picks result position in bytes
// - Twelve-bit result held across two bytes
// - Channel bits select input 0..7 binary
// - At most one input routed to converter; none when powered off or external channel selected
// - Clock select field sets conversion clock
// - Divide system clock by 1..64
// - Start low-high-low begins; high holds reset
// - Completion clears busy, sets interrupt flag
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module adcc_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire adcc_pkg::adcc_bus_t bus,
  output logic [7:0] rdata,
  // Converter macro
  output var adcc_pkg::adcc_conv_t conv,
  input wire logic convDone,
  input wire logic [11:0] convData,
  // Interrupt
  output logic irq
);
  // ==========================================================
  // Register state
  logic startBit;
  logic busy;
  logic powerOff;
  logic align;
  logic [2:0] chanSel;
  logic chanExt;
  logic bandgapEn;
  logic refSel;
  logic [2:0] clkSel;
  logic [11:0] result;
  logic [7:0] intStatus;
  logic [7:0] intMask;
  logic [5:0] divCnt;
  logic convStartPulse;
  logic convTick;

  logic wrMain;
  logic wrAux;
  logic startFall;
  logic finish;
  logic [7:0] resHigh;
  logic [7:0] resLow;
  logic [7:0] next_rdata;

  function automatic logic [5:0] divMask(input logic [2:0] code);
    case (code)
      3'h0: divMask = 6'h00;
      3'h1: divMask = 6'h01;
      3'h2: divMask = 6'h03;
      3'h3: divMask = 6'h07;
      3'h4: divMask = 6'h0f;
      3'h5: divMask = 6'h1f;
      default: divMask = 6'h3f;
    endcase
  endfunction

  assign wrMain = bus.write && bus.addr == adcc_pkg::OFF_MAIN;
  assign wrAux = bus.write && bus.addr == adcc_pkg::OFF_AUX;
  assign startFall = wrMain && startBit &&
                     !bus.wdata[adcc_pkg::MAIN_START];
  assign finish = busy && !startBit && convDone;

  // ==========================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (rst) begin
      startBit <= adcc_pkg::RST_MAIN[adcc_pkg::MAIN_START];
      powerOff <= adcc_pkg::RST_MAIN[adcc_pkg::MAIN_POWER_OFF];
      align <= adcc_pkg::RST_MAIN[adcc_pkg::MAIN_ALIGN];
      chanSel <= adcc_pkg::RST_MAIN[adcc_pkg::MAIN_CHAN_LSB +: 3];
    end else if (wrMain) begin
      startBit <= bus.wdata[adcc_pkg::MAIN_START];
      powerOff <= bus.wdata[adcc_pkg::MAIN_POWER_OFF];
      align <= bus.wdata[adcc_pkg::MAIN_ALIGN];
      chanSel <= bus.wdata[adcc_pkg::MAIN_CHAN_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chanExt <= adcc_pkg::RST_AUX[adcc_pkg::AUX_EXT];
      bandgapEn <= adcc_pkg::RST_AUX[adcc_pkg::AUX_BANDGAP];
      refSel <= adcc_pkg::RST_AUX[adcc_pkg::AUX_REF];
      clkSel <= adcc_pkg::RST_AUX[adcc_pkg::AUX_CLK_LSB +: 3];
    end else if (wrAux) begin
      chanExt <= bus.wdata[adcc_pkg::AUX_EXT];
      bandgapEn <= bus.wdata[adcc_pkg::AUX_BANDGAP];
      refSel <= bus.wdata[adcc_pkg::AUX_REF];
      clkSel <= bus.wdata[adcc_pkg::AUX_CLK_LSB +: 3];
    end
  end

  // ==========================================================
  // Start sequencing and busy flag
  // Busy only drops on a real completion, so a power-off start stays busy
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= adcc_pkg::RST_MAIN[adcc_pkg::MAIN_BUSY];
    end else if (startBit || (wrMain && bus.wdata[adcc_pkg::MAIN_START])) begin
      busy <= 1'b1;
    end else if (finish) begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      convStartPulse <= 1'b0;
    end else begin
      convStartPulse <= startFall && !powerOff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result <= 12'h000;
    end else if (finish) begin
      result <= convData;
    end
  end

  // ==========================================================
  // Conversion clock divider
  // Code 111 is undefined: the tick stops rather than guess a ratio
  always_ff @(posedge clk) begin
    if (rst || powerOff) begin
      divCnt <= 6'h00;
      convTick <= 1'b0;
    end else begin
      divCnt <= divCnt + 6'h01;
      convTick <= clkSel != adcc_pkg::CLK_UNDEFINED &&
                  (divCnt & divMask(clkSel)) == divMask(clkSel);
    end
  end

  // ==========================================================
  // Converter control outputs
  always_comb begin
    conv.powerOn = !powerOff;
    conv.convReset = startBit || powerOff;
    conv.convStart = convStartPulse;
    conv.convClkTick = convTick;
    conv.analogSelect = 8'h00;
    if (!powerOff && !chanExt) begin
      conv.analogSelect[chanSel] = 1'b1;
    end
    conv.bandgapEnable = bandgapEn;
    conv.bandgapRoute = chanExt && bandgapEn && !powerOff;
    conv.refExternal = refSel;
  end

  // ==========================================================
  // Interrupt status and mask
  always_ff @(posedge clk) begin
    if (rst) begin
      intStatus <= adcc_pkg::RST_INT;
    end else begin
      // Set wins over a simultaneous write-one clear
      for (int i = 0; i < 8; i++) begin
        if (i == adcc_pkg::INT_DONE && finish) begin
          intStatus[i] <= 1'b1;
        end else if (bus.write && bus.addr == adcc_pkg::OFF_INT_STATUS &&
                     bus.wdata[i]) begin
          intStatus[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      intMask <= adcc_pkg::RST_INT;
    end else if (bus.write && bus.addr == adcc_pkg::OFF_INT_MASK) begin
      intMask <= bus.wdata;
    end
  end

  assign irq = |(intStatus & intMask);

  // ==========================================================
  // Read path
  always_comb begin
    if (align) begin
      resHigh = {4'h0, result[11:8]};
      resLow = result[7:0];
    end else begin
      resHigh = result[11:4];
      resLow = {result[3:0], 4'h0};
    end
    unique case (bus.addr)
      adcc_pkg::OFF_MAIN: next_rdata = {startBit, busy, powerOff, align,
                                        1'b0, chanSel};
      adcc_pkg::OFF_AUX: next_rdata = {chanExt, bandgapEn, 1'b0, refSel,
                                       1'b0, clkSel};
      adcc_pkg::OFF_RES_HIGH: next_rdata = resHigh;
      adcc_pkg::OFF_RES_LOW: next_rdata = resLow;
      adcc_pkg::OFF_INT_STATUS: next_rdata = intStatus;
      adcc_pkg::OFF_INT_MASK: next_rdata = intMask;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.read) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  sequence readHigh;
    bus.read && bus.addr == adcc_pkg::OFF_RES_HIGH;
  endsequence

  sequence startRelease;
    startFall && !powerOff;
  endsequence

  a_align_clear: assert property (@(posedge clk) disable iff (rst)
    readHigh and !align |=> rdata == $past(result[11:4]))
    else $error("high byte wrong with alignment clear");
  a_align_set: assert property (@(posedge clk) disable iff (rst)
    readHigh and align |=> rdata == {4'h0, $past(result[11:8])})
    else $error("high byte wrong with alignment set");
  a_result_hold: assert property (@(posedge clk) disable iff (rst)
    !finish |=> $stable(result))
    else $error("result changed without completion");
  a_chan_route: assert property (@(posedge clk) disable iff (rst)
    !powerOff && !chanExt |-> conv.analogSelect == 8'h01 << chanSel)
    else $error("wrong input routed");
  a_one_input: assert property (@(posedge clk) disable iff (rst)
    $countones(conv.analogSelect) <= 1)
    else $error("more than one input routed");
  a_clk_undef: assert property (@(posedge clk) disable iff (rst)
    clkSel == adcc_pkg::CLK_UNDEFINED [*2] |-> !conv.convClkTick)
    else $error("tick with undefined clock code");
  // Only one step is claimed, so a code change right after is no hazard
  a_div_half: assert property (@(posedge clk) disable iff (rst)
    (clkSel == 3'h1 && !powerOff) [*3]
    |=> conv.convClkTick != $past(conv.convClkTick))
    else $error("divide by two period wrong");
  a_start_seq: assert property (@(posedge clk) disable iff (rst)
    startRelease |=> conv.convStart ##1 !conv.convStart && busy)
    else $error("start pulse missing after release");
  a_start_hold: assert property (@(posedge clk) disable iff (rst)
    startBit |-> conv.convReset && busy)
    else $error("held start does not reset");
  a_done_flag: assert property (@(posedge clk) disable iff (rst)
    finish |=> !busy && intStatus[adcc_pkg::INT_DONE] &&
    (irq == intMask[adcc_pkg::INT_DONE] || $past(intMask) != intMask))
    else $error("completion flags wrong");
  a_power_off: assert property (@(posedge clk) disable iff (rst)
    powerOff [*2] |-> !conv.powerOn && conv.analogSelect == 8'h00 &&
    !conv.convClkTick && !conv.convStart)
    else $error("converter active while powered off");
endmodule
`default_nettype wire

// file: hdl/adcc_pkg.sv
// Package with register map, field positions and types for the ADC control
package adcc_pkg;
  // ==========================================================
  // Register map (word index on the plain register port)
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_MAIN = 3'h0;
  localparam logic [2:0] OFF_AUX = 3'h1;
  localparam logic [2:0] OFF_RES_HIGH = 3'h2;
  localparam logic [2:0] OFF_RES_LOW = 3'h3;
  localparam logic [2:0] OFF_INT_STATUS = 3'h4;
  localparam logic [2:0] OFF_INT_MASK = 3'h5;

  // ==========================================================
  // Field positions of adc_control_main
  localparam int MAIN_START = 7;
  localparam int MAIN_BUSY = 6;
  localparam int MAIN_POWER_OFF = 5;
  localparam int MAIN_ALIGN = 4;
  localparam int MAIN_CHAN_LSB = 0;

  // ==========================================================
  // Field positions of adc_control_aux
  localparam int AUX_EXT = 7;
  localparam int AUX_BANDGAP = 6;
  localparam int AUX_REF = 4;
  localparam int AUX_CLK_LSB = 0;

  // ==========================================================
  // Interrupt status bits and reset values
  localparam int INT_DONE = 0;
  localparam logic [7:0] RST_MAIN = 8'h60;
  localparam logic [7:0] RST_AUX = 8'h00;
  localparam logic [7:0] RST_INT = 8'h00;
  localparam logic [2:0] CLK_UNDEFINED = 3'h7;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } adcc_bus_t;

  typedef struct packed {
    logic powerOn;
    logic convReset;
    logic convStart;
    logic convClkTick;
    logic [7:0] analogSelect;
    logic bandgapEnable;
    logic bandgapRoute;
    logic refExternal;
  } adcc_conv_t;
endpackage

// file: tb/adcc_control_tb.sv
// Self-checking bench for the ADC control registers
`timescale 1ns/10ps
`default_nettype none
module adcc_control_tb;
  // ==========================================================
  // Stimulus and observation
  logic clk = 1'b0;
  logic rst = 1'b1;
  adcc_pkg::adcc_bus_t bus = '0;
  logic [7:0] rdata;
  adcc_pkg::adcc_conv_t conv;
  logic convDone = 1'b0;
  logic [11:0] convData = 12'h000;
  logic irq;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] n;

  always #5 clk = ~clk;

  adcc_control u_adcc_control (.clk(clk), .rst(rst), .bus(bus),
    .rdata(rdata), .conv(conv), .convDone(convDone),
    .convData(convData), .irq(irq));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    bus.write <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
    @(posedge clk);
    bus.read <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Full start sequence; ctl holds the non-start main bits
  task automatic convert(input logic [11:0] d, input logic [7:0] ctl);
    wr(adcc_pkg::OFF_MAIN, 8'h80 | ctl);
    #1 chk(conv.convReset, 1'b1);
    wr(adcc_pkg::OFF_MAIN, ctl);
    #1 chk(conv.convStart, 1'b1);
    rd(adcc_pkg::OFF_MAIN, 8'h40 | ctl);
    @(posedge clk);
    convDone <= 1'b1;
    convData <= d;
    @(posedge clk);
    convDone <= 1'b0;
    rd(adcc_pkg::OFF_MAIN, ctl);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd(adcc_pkg::OFF_MAIN, 8'h60);
    @(posedge clk) #1 chk(rdata, 8'h00);
    rd(adcc_pkg::OFF_AUX, 8'h00);
    rd(adcc_pkg::OFF_INT_STATUS, 8'h00);
    rd(adcc_pkg::OFF_INT_MASK, 8'h00);
    rd(3'h6, 8'h00);
    chk(conv.powerOn, 1'b0);
    chk(conv.analogSelect, 8'h00);
  endtask

  task automatic t_route;
    for (int c = 0; c < 8; c++) begin
      wr(adcc_pkg::OFF_MAIN, 8'(c));
      #1 chk(conv.analogSelect, 8'h01 << c);
      chk(conv.powerOn, 1'b1);
    end
    wr(adcc_pkg::OFF_AUX, 8'hd0);
    #1 chk(conv.bandgapRoute, 1'b1);
    chk(conv.analogSelect, 8'h00);
    chk(conv.bandgapEnable, 1'b1);
    chk(conv.refExternal, 1'b1);
    wr(adcc_pkg::OFF_AUX, 8'h40);
    #1 chk(conv.bandgapRoute, 1'b0);
    chk(conv.bandgapEnable, 1'b1);
    chk(conv.refExternal, 1'b0);
    rd(adcc_pkg::OFF_AUX, 8'h40);
    wr(adcc_pkg::OFF_AUX, 8'h80);
    #1 chk(conv.analogSelect, 8'h00);
  endtask

  task automatic t_clock;
    for (int k = 0; k < 8; k++) begin
      wr(adcc_pkg::OFF_AUX, 8'(k));
      repeat (3) @(posedge clk);
      n = 8'h00;
      repeat (128) begin
        @(posedge clk) #1;
        n = n + 8'(conv.convClkTick);
      end
      chk(n, (k == 7) ? 8'h00 : 8'(128 >> k));
    end
  endtask

  task automatic t_convert;
    wr(adcc_pkg::OFF_INT_MASK, 8'h01);
    convert(12'habc, 8'h00);
    #1 chk(irq, 1'b1);
    rd(adcc_pkg::OFF_RES_HIGH, 8'hab);
    rd(adcc_pkg::OFF_RES_LOW, 8'hc0);
    wr(adcc_pkg::OFF_MAIN, 8'h10);
    rd(adcc_pkg::OFF_RES_HIGH, 8'h0a);
    rd(adcc_pkg::OFF_RES_LOW, 8'hbc);
    wr(adcc_pkg::OFF_INT_STATUS, 8'h01);
    #1 chk(irq, 1'b0);
    wr(adcc_pkg::OFF_INT_MASK, 8'h00);
    convert(12'h5a3, 8'h10);
    rd(adcc_pkg::OFF_INT_STATUS, 8'h01);
    chk(irq, 1'b0);
    rd(adcc_pkg::OFF_RES_LOW, 8'ha3);
  endtask

  // A start while powered off must not reach the converter
  task automatic t_poweroff;
    wr(adcc_pkg::OFF_MAIN, 8'h20);
    #1 chk(conv.powerOn, 1'b0);
    chk(conv.convReset, 1'b1);
    chk(conv.analogSelect, 8'h00);
    wr(adcc_pkg::OFF_MAIN, 8'ha0);
    wr(adcc_pkg::OFF_MAIN, 8'h20);
    #1 chk(conv.convStart, 1'b0);
    rd(adcc_pkg::OFF_MAIN, 8'h60);
  endtask

  // ==========================================================
  // Run control
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_route();
    t_clock();
    t_convert();
    t_poweroff();
    tally_and_finish();
  end

  // Whole run is about 1200 cycles; the 20000-cycle limit allows ample margin
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
